// File: hdl/adr_pkg.sv
package adr_pkg;

	localparam int NUM_CH       = 8;
	localparam int STATUS_BITS  = 24;
	localparam int SAMPLE_WIDE  = 24;
	localparam int SAMPLE_NARROW = 16;
	localparam int FRAME_WIDE   = STATUS_BITS + SAMPLE_WIDE * NUM_CH;
	localparam int FIFO_DEPTH   = 16;
	localparam int PEND_BITS    = SAMPLE_WIDE * NUM_CH;

	localparam logic [7:0] FRAME_BITS_WIDE   = 8'hD8;
	localparam logic [7:0] FRAME_BITS_NARROW = 8'h98;

	localparam logic [2:0] RATE_16_FAST   = 3'h0;
	localparam logic [2:0] RATE_16_SLOW   = 3'h1;

	localparam logic [7:0] OP_CONT_READ   = 8'h10;
	localparam logic [7:0] OP_STOP_CONT   = 8'h11;
	localparam logic [6:0] OP_SINGLE_HEAD = 7'h09;
	localparam logic [2:0] SINGLE_DECODE_CNT = 3'h6;
	localparam logic [2:0] BYTE_LAST_CNT     = 3'h7;
	localparam logic [2:0] LAST_WORD_IDX     = 3'h7;

	localparam logic [3:0]  STATUS_MARK  = 4'hC;
	localparam logic [15:0] SAT_POS_16   = 16'h7FFF;
	localparam logic [15:0] SAT_NEG_16   = 16'h8000;

	localparam logic       CONT_AT_RESET = 1'h1;
	localparam logic       DATA_READY_N_N_RESET  = 1'h1;
	localparam logic [1:0] CS_SYNC_RESET = 2'h3;

	typedef struct packed {
		logic [7:0] positive_fault_flags;
		logic [7:0] negative_fault_flags;
		logic [3:0] gpio_data;
	} adr_status_t;

	typedef struct packed {
		logic [2:0] rate_select;
		logic       repeat_readback_enable;
		logic [7:0] channel_power_down;
	} adr_config_t;

	typedef struct packed {
		logic [1:0]            cs_sync;
		logic [1:0]            sclk_sync;
		logic [1:0]            din_sync;
		logic                  sclk_prev;
		logic [2:0]            cmd_cnt;
		logic [6:0]            cmd_sh;
		logic                  cont_mode;
		logic                  single_pend;
		logic                  tx_active;
		logic [7:0]            tx_idx;
		logic [FRAME_WIDE-1:0] tx_frame;
		logic [FRAME_WIDE-1:0] ready_frame;
		logic                  ready_valid;
		logic [2:0]            word_cnt;
		logic [PEND_BITS-1:0]  pend;
		logic                  data_ready_n_n;
		logic                  dout;
	} adr_state_t;

endpackage : adr_pkg

// File: hdl/adr_readout.sv
`timescale 1ns/1ps

module adr_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        full;
		logic                        empty;
	} adr_fifo_state_t;

	adr_fifo_state_t st_reg;
	adr_fifo_state_t st_next;
	logic            push;
	logic            pop;

	assign in_ready  = ~st_reg.full;
	assign out_valid = ~st_reg.empty;
	assign out_data  = st_reg.mem[st_reg.rp];

	always_comb begin
		st_next = st_reg;
		push    = in_valid & ~st_reg.full;
		pop     = out_ready & ~st_reg.empty;
		if (push) begin
			st_next.mem[st_reg.wp] = in_data;
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (pop) begin
			st_next.rp = st_reg.rp + 1'b1;
		end
		if (push && !pop) begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end else if (pop && !push) begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end
		st_next.full  = (st_next.cnt == (AW+1)'(DEPTH));
		st_next.empty = (st_next.cnt == '0);
		if (reset) begin
			st_next       = '0;
			st_next.empty = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		st_reg <= st_next;
	end

endmodule : adr_fifo

module adr_readout
	import adr_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic                   cs_n,
	input  wire logic                   sclk,
	input  wire logic                   din,
	output logic                        dout,
	output logic                        dout_oe_n,
	output logic                        data_ready_n,
	output logic                        continuous_read_mode,
	input  wire logic [SAMPLE_WIDE-1:0] conv_data,
	input  wire logic                   conv_valid,
	output logic                        conv_ready,
	input  wire adr_status_t            fault_status,
	input  wire adr_config_t            config_in
);

	adr_state_t             st_reg;
	adr_state_t             st_next;
	logic                   fifo_valid;
	logic                   fifo_pop;
	logic [SAMPLE_WIDE-1:0] fifo_data;

	function automatic logic is_narrow(input logic [2:0] rate);
		is_narrow = (rate == RATE_16_FAST) || (rate == RATE_16_SLOW);
	endfunction : is_narrow

	function automatic logic [SAMPLE_NARROW-1:0] sat16(
		input logic [SAMPLE_WIDE-1:0] s
	);
		if (!s[SAMPLE_WIDE-1] && (s[SAMPLE_WIDE-2:SAMPLE_NARROW-1] != '0)) begin
			sat16 = SAT_POS_16;
		end else if (s[SAMPLE_WIDE-1] &&
			(s[SAMPLE_WIDE-2:SAMPLE_NARROW-1] != '1)) begin
			sat16 = SAT_NEG_16;
		end else begin
			sat16 = s[SAMPLE_NARROW-1:0];
		end
	endfunction : sat16

	// Frame is MSB aligned; narrow frames leave unused low bits at zero
	function automatic logic [FRAME_WIDE-1:0] build_frame(
		input adr_status_t           stat,
		input logic [PEND_BITS-1:0]  smp,
		input adr_config_t           cfg
	);
		logic [SAMPLE_WIDE-1:0] s;
		build_frame = '0;
		s = '0;
		build_frame[FRAME_WIDE-1 -: STATUS_BITS] = {STATUS_MARK,
			stat.positive_fault_flags, stat.negative_fault_flags,
			stat.gpio_data};
		for (int ch = 0; ch < NUM_CH; ch++) begin
			s = cfg.channel_power_down[ch] ? '0 :
				smp[ch*SAMPLE_WIDE +: SAMPLE_WIDE];
			if (is_narrow(cfg.rate_select)) begin
				build_frame[FRAME_WIDE-1-STATUS_BITS-ch*SAMPLE_NARROW
					-: SAMPLE_NARROW] = sat16(s);
			end else begin
				build_frame[FRAME_WIDE-1-STATUS_BITS-ch*SAMPLE_WIDE
					-: SAMPLE_WIDE] = s;
			end
		end
	endfunction : build_frame

	// Samples queue here so the converter can run ahead of a slow readout
	adr_fifo #(
		.WIDTH (SAMPLE_WIDE),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (conv_valid),
		.in_ready  (conv_ready),
		.in_data   (conv_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// A frame is only latched between readouts, which stalls the queue
	assign fifo_pop = ~st_reg.tx_active;

	always_comb begin
		logic                 cs_hi;
		logic                 sck;
		logic                 din_s;
		logic                 rise;
		logic                 fall;
		logic [7:0]           cmd_byte;
		logic [7:0]           len;
		logic [PEND_BITS-1:0] smp;
		cs_hi    = st_reg.cs_sync[1];
		sck      = st_reg.sclk_sync[1];
		din_s    = st_reg.din_sync[1];
		rise     = sck & ~st_reg.sclk_prev;
		fall     = ~sck & st_reg.sclk_prev;
		cmd_byte = {st_reg.cmd_sh, din_s};
		len      = is_narrow(config_in.rate_select) ? FRAME_BITS_NARROW :
			FRAME_BITS_WIDE;
		smp      = st_reg.pend;
		st_next  = st_reg;

		st_next.cs_sync   = {st_reg.cs_sync[0], cs_n};
		st_next.sclk_sync = {st_reg.sclk_sync[0], sclk};
		st_next.din_sync  = {st_reg.din_sync[0], din};
		st_next.sclk_prev = sck;

		// Clear happens even with chip select high
		if (fall) begin
			st_next.data_ready_n_n = 1'b1;
		end

		if (cs_hi) begin
			st_next.cmd_cnt     = '0;
			st_next.tx_active   = 1'b0;
			st_next.tx_idx      = '0;
			st_next.single_pend = 1'b0;
		end else begin
			if (fall) begin
				st_next.cmd_sh  = cmd_byte[6:0];
				st_next.cmd_cnt = st_reg.cmd_cnt + 1'b1;
				if (st_reg.cmd_cnt == SINGLE_DECODE_CNT &&
					cmd_byte[6:0] == OP_SINGLE_HEAD) begin
					st_next.single_pend = 1'b1;
				end
				if (st_reg.cmd_cnt == BYTE_LAST_CNT) begin
					if (cmd_byte == OP_CONT_READ) begin
						st_next.cont_mode = 1'b1;
					end else if (cmd_byte == OP_STOP_CONT) begin
						st_next.cont_mode = 1'b0;
					end
				end
			end
			if (rise) begin
				if (st_reg.tx_active) begin
					if (st_reg.tx_idx == len) begin
						if (config_in.repeat_readback_enable) begin
							st_next.dout   = st_reg.tx_frame[FRAME_WIDE-1];
							st_next.tx_idx = 8'h01;
						end else begin
							st_next.dout      = 1'b0;
							st_next.tx_active = 1'b0;
						end
					end else begin
						st_next.dout   = st_reg.tx_frame[
							FRAME_WIDE-1-int'(st_reg.tx_idx)];
						st_next.tx_idx = st_reg.tx_idx + 1'b1;
					end
				end else if (st_reg.cmd_cnt == '0 && st_reg.tx_idx == '0 &&
					(st_reg.single_pend ||
					(st_reg.cont_mode && st_reg.ready_valid))) begin
					// Private copy; no new frame lands mid-readout, as the fifo is not popped while tx_active
					st_next.tx_frame    = st_reg.ready_frame;
					st_next.dout        = st_reg.ready_frame[FRAME_WIDE-1];
					st_next.tx_idx      = 8'h01;
					st_next.tx_active   = 1'b1;
					st_next.single_pend = 1'b0;
					st_next.ready_valid = 1'b0;
				end
			end
		end

		if (fifo_valid && fifo_pop) begin
			smp[8'(st_reg.word_cnt) * 8'd24 +: SAMPLE_WIDE] = fifo_data;
			st_next.pend     = smp;
			st_next.word_cnt = st_reg.word_cnt + 1'b1;
			if (st_reg.word_cnt == LAST_WORD_IDX) begin
				st_next.ready_frame = build_frame(fault_status, smp, config_in);
				st_next.ready_valid = 1'b1;
				st_next.data_ready_n_n      = 1'b0;
				if (st_reg.cont_mode && !cs_hi && !rise) begin
					st_next.dout = 1'b0;
				end
			end
		end

		if (reset) begin
			st_next           = '0;
			st_next.cont_mode = CONT_AT_RESET;
			st_next.data_ready_n_n    = DATA_READY_N_N_RESET;
			st_next.cs_sync   = CS_SYNC_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		st_reg <= st_next;
	end

	assign dout                 = st_reg.dout;
	assign dout_oe_n            = st_reg.cs_sync[1];
	assign data_ready_n         = st_reg.data_ready_n_n;
	assign continuous_read_mode = st_reg.cont_mode;

endmodule : adr_readout

// File: verification/adr_host_model.sv
`timescale 1ns/1ps
module adr_host (
	input  wire logic core_clk,
	input  wire logic dout,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	logic [231:0] rx;
	initial begin
		cs_n = 1'h1;
		sclk = 1'h0;
		din  = 1'h0;
	end
	// Leaves a gap of four cycles after chip select moves
	task sel(input logic v);
		@(posedge core_clk);
		cs_n <= v;
		repeat (4) @(posedge core_clk);
	endtask : sel
	// Command bits first; din then held low through the read
	task xfer(input logic [7:0] c, input int nc, input int nb);
		for (int i = 0; i < nc + nb; i++) begin
			@(posedge core_clk);
			din  <= (i < nc) ? c[7-i] : 1'h0;
			sclk <= 1'h1;
			repeat (4) @(posedge core_clk);
			// Sampled at the end of the high phase, just before the fall
			rx   <= {rx[230:0], dout};
			sclk <= 1'h0;
			repeat (3) @(posedge core_clk);
		end
	endtask : xfer
endmodule : adr_host

// File: verification/adr_readout_checker.sv
`timescale 1ns/1ps
module adr_readout_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout,
	input wire logic dout_oe_n,
	input wire logic data_ready_n,
	input wire logic continuous_read_mode
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	a_reset_idle: assert property (
		$past(reset) |-> data_ready_n && continuous_read_mode && dout_oe_n)
		else $error("outputs not idle after reset");
	a_oe_follows_cs: assert property (
		$stable(cs_n) && cs_n == $past(cs_n, 2) && cs_n == $past(cs_n, 3)
		|-> dout_oe_n == cs_n) else $error("output enable off chip select");
	a_oe_on_select: assert property (
		$fell(cs_n) |-> ##[2:3] !dout_oe_n)
		else $error("output not enabled after select");
	a_data_ready_n_dout_low: assert property (
		$fell(data_ready_n) && !dout_oe_n && continuous_read_mode |-> !dout)
		else $error("output not low with new frame");
	a_data_ready_n_clears: assert property (
		$fell(sclk) |-> ##[1:5] data_ready_n)
		else $error("data ready not cleared by clock fall");
	a_data_ready_n_holds: assert property (
		!data_ready_n && !sclk && !$past(sclk) && !$past(sclk, 2)
		&& !$past(sclk, 3) && !$past(sclk, 4) |=> !data_ready_n)
		else $error("data ready released without clock");
	a_dout_on_rise: assert property (
		$changed(dout) && !dout_oe_n && !$past(dout_oe_n) && data_ready_n
		|-> $past(sclk, 3)) else $error("output moved off a rising edge");
	a_mode_on_fall: assert property (
		$changed(continuous_read_mode)
		|-> !dout_oe_n && !sclk && !$past(sclk, 2))
		else $error("mode changed off a falling edge");
endmodule : adr_readout_checker

bind adr_readout adr_readout_checker chk_u (.core_clk, .reset, .cs_n,
	.sclk, .dout, .dout_oe_n, .data_ready_n, .continuous_read_mode);

// File: verification/tb.sv
`timescale 1ns/1ps
module tb import adr_pkg::*;;
	logic         core_clk, reset, cs_n, sclk, din, dout, dout_oe_n;
	logic         data_ready_n, continuous_read_mode, conv_valid, conv_ready;
	logic [23:0]  conv_data, a[8], b[8];
	logic [215:0] expf;
	adr_status_t  fault_status;
	adr_config_t  config_in;
	int           mismatches, checked, cyc, k;

	adr_readout dut_u (.core_clk, .reset, .cs_n, .sclk, .din, .dout,
		.dout_oe_n, .data_ready_n, .continuous_read_mode, .conv_data,
		.conv_valid, .conv_ready, .fault_status, .config_in);
	adr_host host_u (.core_clk, .dout, .cs_n, .sclk, .din);

	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	task chk(input logic [215:0] got, input logic [215:0] want);
		checked++;
		if (got !== want) begin
			mismatches++;
			$display("unexpected at %0t got %h want %h", $time, got, want);
		end
	endtask : chk

	task close_out;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// Reference frame built from the current settings
	function automatic logic [215:0] frame(input logic [23:0] s[8]);
		logic [215:0] f;
		int           v;
		f = {STATUS_MARK, fault_status};
		for (int i = 0; i < 8; i++) begin
			v = config_in.channel_power_down[i] ? 0 : $signed(s[i]);
			if (config_in.rate_select < 3'h2) begin
				v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
				f = {f[199:0], v[15:0]};
			end else
				f = {f[191:0], v[23:0]};
		end
		return f;
	endfunction : frame

	task feed(input logic [23:0] w[8], input int n);
		conv_valid <= 1'h1;
		for (int i = 0; i < n; i++) begin
			conv_data <= w[i % 8];
			// Ready is looked at mid-cycle, where it has settled
			@(negedge core_clk);
			while (conv_ready !== 1'h1) @(negedge core_clk);
			@(posedge core_clk);
		end
		conv_valid <= 1'h0;
	endtask : feed

	task wait_new;
		@(negedge core_clk);
		while (data_ready_n !== 1'h0) @(negedge core_clk);
	endtask : wait_new

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			close_out;
		end
	end

	initial begin
		reset = 1'h1;
		conv_valid = 1'h0;
		conv_data = 24'h0;
		fault_status = '0;
		config_in = '0;
		k = $urandom(75);
		repeat (4) @(posedge core_clk);
		reset <= 1'h0;
		repeat (4) @(posedge core_clk);
		chk(data_ready_n, 1'h1);
		chk(continuous_read_mode, 1'h1);
		chk(dout_oe_n, 1'h1);
		$display("test reset done");
		fault_status <= 20'($urandom);
		config_in <= {3'h2 + 3'($urandom % 5), 1'h0, 8'($urandom)};
		for (int i = 0; i < 8; i++) begin
			a[i] = 24'($urandom);
			b[i] = 24'($urandom);
		end
		host_u.sel(1'h0);
		feed(a, 8);
		wait_new;
		chk(dout, 1'h0);
		expf = frame(a);
		// Fifo stalls during readout, so sixteen words fill it
		fork
			host_u.xfer(8'h00, 0, 216);
			begin
				repeat (80) @(posedge core_clk);
				feed(b, 16);
				@(posedge core_clk);
				chk(conv_ready, 1'h0);
			end
		join
		chk(host_u.rx[215:0], expf);
		host_u.sel(1'h1);
		repeat (40) @(posedge core_clk);
		host_u.sel(1'h0);
		host_u.xfer(8'h00, 0, 216);
		chk(host_u.rx[215:0], frame(b));
		host_u.sel(1'h1);
		$display("test continuous done");
		config_in <= {3'($urandom % 2), 1'h1, 8'h00};
		a = '{24'h7FFFFF, 24'h800000, 24'h000001, 24'h000000,
			24'hFFFFFF, 24'h012345, 24'hFEDCBA, 24'($urandom % 32768)};
		host_u.sel(1'h0);
		feed(a, 8);
		wait_new;
		expf = frame(a);
		host_u.xfer(8'h00, 0, 160);
		chk(host_u.rx[159:0], {expf[151:0], expf[151:144]});
		host_u.sel(1'h1);
		$display("test narrow done");
		config_in <= {3'h3, 1'h0, 8'h81};
		host_u.sel(1'h0);
		host_u.xfer(OP_STOP_CONT, 8, 0);
		repeat (2) @(posedge core_clk);
		chk(continuous_read_mode, 1'h0);
		host_u.sel(1'h1);
		feed(a, 8);
		wait_new;
		host_u.xfer(8'h00, 0, 1);
		repeat (4) @(posedge core_clk);
		chk(data_ready_n, 1'h1);
		chk(dout_oe_n, 1'h1);
		host_u.sel(1'h0);
		host_u.xfer(8'h12, 8, 216);
		chk(host_u.rx[215:0], frame(a));
		host_u.xfer(OP_CONT_READ, 8, 0);
		repeat (2) @(posedge core_clk);
		chk(continuous_read_mode, 1'h1);
		host_u.sel(1'h1);
		$display("test command done");
		close_out;
	end
endmodule : tb
